// File: bus_hold_consts.vh
// constants for the external bus hold arbiter and reset float logic
// assumes one processor clock; all counts are in periods of that clock
// Notes on behaviour
// - hold request is asynchronous; two flip-flops sample it before use
// - bus floats no sooner than four clocks after request goes low
// - grant goes low within two clocks after bus floats
// - grant releases four to seven clocks after request goes high
// - bus driven again three to six clocks after request goes high
// - pending external access completes before grant is given
// - grant may wait for ready-stretched access or eight-burst sdram run
// - with bus idle, grant comes after only the minimum delay
// - hold-ignore setting high defers the grant while it stays high; the code checks it only in idle, before draining starts
// - chip enables, byte enables, data, address and all strobes float when granted
// - response to reset input change comes no sooner than one clock
// - bus, host data and serial clock, frame, transmit pins float in reset
`ifndef BUS_HOLD_CONSTS_VH
`define BUS_HOLD_CONSTS_VH
`define CLK_PERIOD_NS 8
`define FLOAT_DELAY_P 4
`define GRANT_DELAY_P 1
`define RELEASE_DRIVE_P 4
`define RELEASE_GRANT_P 5
`define CNT_W 3
`define SYNC_STAGES 2
`define SYNC_LAT_P 3
`define ONE_CLK_P 1
`endif

// File: ext_bus_hold_and_reset_release.v
// hold arbiter for the external memory port plus reset-time float control
// assumes access_busy comes from the memory controller on ref_clk; hold_req_n is asynchronous
// assumes sys_rst and hold_ignore_setting already live on ref_clk
`timescale 1ns/1ps
`include "bus_hold_consts.vh"
module ext_bus_hold_and_reset_release
#(
    parameter FLOAT_DELAY = `FLOAT_DELAY_P,
    parameter GRANT_DELAY = `GRANT_DELAY_P,
    parameter RELEASE_DRIVE = `RELEASE_DRIVE_P,
    parameter RELEASE_GRANT = `RELEASE_GRANT_P,
    parameter CNT_W = `CNT_W
)
(
    input wire ref_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire hold_req_n,
    input wire hold_ignore_setting,
    input wire access_busy,
    output wire access_inhibit,
    output reg bus_hold_grant_n,
    output reg ext_bus_float,
    output reg reset_float,
    output wire ext_bus_oe_n,
    output wire host_serial_oe_n
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DRAIN = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_FLOAT = 3'h3;
    localparam ST_GRANT = 3'h4;
    localparam ST_UNFLOAT = 3'h5;
    localparam ST_UNGRANT = 3'h6;

    // the synchroniser and the idle decode already spend part of each delay
    localparam FLOAT_WAIT = FLOAT_DELAY - `SYNC_LAT_P;
    localparam GRANT_WAIT = GRANT_DELAY - `ONE_CLK_P;
    localparam DRIVE_WAIT = RELEASE_DRIVE - `SYNC_LAT_P;
    localparam UNGRANT_WAIT = RELEASE_GRANT - RELEASE_DRIVE - `ONE_CLK_P;

    wire req_n_sync;
    wire req_sync;
    wire start_ok;
    wire drain_done;
    wire float_due;
    wire grant_due;
    wire drive_due;
    wire ungrant_due;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [CNT_W-1:0] cnt;
    reg [CNT_W-1:0] next_cnt;
    reg next_float;
    reg next_grant_n;
    reg rst_seen;

    // a request missing the sampling edge lands one clock later
    level_sync
    #(
        .STAGES(`SYNC_STAGES),
        .RESET_VAL(1'b1)
    )
    req_sync_inst
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(hold_req_n),
        .sync_out(req_n_sync)
    );

    assign req_sync = ~req_n_sync;

    assign start_ok = req_sync && !hold_ignore_setting;
    assign drain_done = !access_busy;
    assign float_due = (cnt >= FLOAT_WAIT);
    assign grant_due = (cnt >= GRANT_WAIT);
    assign drive_due = (cnt >= DRIVE_WAIT);
    assign ungrant_due = (cnt >= UNGRANT_WAIT);

    // float/grant sequence; counts start once the request leaves the synchroniser
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (start_ok)
                begin
                    next_state = ST_DRAIN;
                end
            end

            ST_DRAIN:
            begin
                if (!req_sync)
                begin
                    next_state = ST_IDLE;
                end
                else if (drain_done)
                begin
                    next_state = ST_WAIT;
                end
            end

            ST_WAIT:
            begin
                // a request dropped before the float is abandoned quietly
                if (!req_sync)
                begin
                    next_state = ST_IDLE;
                end
                else if (float_due)
                begin
                    next_state = ST_FLOAT;
                end
            end

            ST_FLOAT:
            begin
                if (grant_due)
                begin
                    next_state = ST_GRANT;
                end
            end

            ST_GRANT:
            begin
                if (!req_sync)
                begin
                    next_state = ST_UNFLOAT;
                end
            end

            ST_UNFLOAT:
            begin
                if (drive_due)
                begin
                    next_state = ST_UNGRANT;
                end
            end

            ST_UNGRANT:
            begin
                if (ungrant_due)
                begin
                    next_state = ST_IDLE;
                end
            end

            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // the drain count runs on into the float wait, so a drain floats at once unless it lasted a multiple of eight clocks
    always @*
    begin
        next_cnt = cnt + 1'b1;
        if ((state == ST_IDLE) || (state == ST_GRANT))
        begin
            next_cnt = {CNT_W{1'b0}};
        end
        else if ((next_state == ST_FLOAT) || (next_state == ST_GRANT) || (next_state == ST_UNGRANT)
            || (next_state == ST_IDLE))
        begin
            next_cnt = {CNT_W{1'b0}};
        end
    end

    // pad controls decoded from the next state so they leave flip-flops
    always @*
    begin
        next_float = 1'b0;
        next_grant_n = 1'b1;
        case (next_state)
            ST_FLOAT:
            begin
                next_float = 1'b1;
            end

            ST_GRANT:
            begin
                next_float = 1'b1;
                next_grant_n = 1'b0;
            end

            ST_UNFLOAT:
            begin
                next_float = 1'b1;
                next_grant_n = 1'b0;
            end

            ST_UNGRANT:
            begin
                next_grant_n = 1'b0;
            end

            default:
            begin
                next_float = 1'b0;
                next_grant_n = 1'b1;
            end
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            cnt <= {CNT_W{1'b0}};
        end
        else if (clk_en)
        begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // grant flop kept apart so the acknowledge pin has no decode glitch
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            bus_hold_grant_n <= 1'b1;
        end
        else if (clk_en)
        begin
            bus_hold_grant_n <= next_grant_n;
        end
    end

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ext_bus_float <= 1'b0;
        end
        else if (clk_en)
        begin
            ext_bus_float <= next_float;
        end
    end

    // reset float ignores clk_en so the pins float on any reset
    always @(posedge ref_clk)
    begin
        rst_seen <= sys_rst;
        reset_float <= rst_seen;
    end

    // no new access from the moment draining ends until the grant is released
    assign access_inhibit = (state != ST_IDLE) && (state != ST_DRAIN);
    assign ext_bus_oe_n = ext_bus_float | reset_float;
    assign host_serial_oe_n = reset_float;
endmodule

// level synchroniser for a pin from outside the clock domain
// only the last stage is read; the first may go metastable
module level_sync
#(
    parameter STAGES = `SYNC_STAGES,
    parameter [0:0] RESET_VAL = 1'b0
)
(
    input wire ref_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire async_in,
    output wire sync_out
);
    reg [STAGES-1:0] stage;

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            stage <= {STAGES{RESET_VAL}};
        end
        else if (clk_en)
        begin
            stage <= {stage[STAGES-2:0], async_in};
        end
    end

    assign sync_out = stage[STAGES-1];
endmodule

// File: hold_monitor.sv
// assertions on the hold arbiter ports
// assumes it is bound onto the arbiter top, one clock
`timescale 1ns/1ps
module hold_monitor
(
    input wire ref_clk,
    input wire sys_rst,
    input wire hold_req_n,
    input wire hold_ignore_setting,
    input wire access_inhibit,
    input wire bus_hold_grant_n,
    input wire ext_bus_float,
    input wire reset_float,
    input wire ext_bus_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    chk_float_min: assert property ($rose(ext_bus_float) |-> !$past(hold_req_n, 4)) else $error("early float");
    chk_grant_max: assert property ($rose(ext_bus_float) |-> ##[0:2] !bus_hold_grant_n) else $error("late grant");
    chk_grant_rel: assert property (
        $rose(hold_req_n) && !bus_hold_grant_n |-> !bus_hold_grant_n[*4] ##[1:3] bus_hold_grant_n) else $error("ungrant");
    chk_drive_rel: assert property (
        $rose(hold_req_n) && ext_bus_float |-> ext_bus_float[*3] ##[1:3] !ext_bus_float) else $error("redrive");
    chk_ignore_on: assert property (
        hold_ignore_setting && !ext_bus_float && bus_hold_grant_n |=> bus_hold_grant_n) else $error("grant ignored");
    chk_hold_keep: assert property (
        !bus_hold_grant_n && !hold_req_n |-> ext_bus_float && access_inhibit) else $error("hold lost");
    chk_bus_oe: assert property (ext_bus_oe_n == (ext_bus_float || reset_float)) else $error("bus enable");
    chk_rst_float: assert property (
        disable iff (1'b0) sys_rst[*4] |-> reset_float && ext_bus_oe_n) else $error("reset float");
    chk_rst_resp: assert property (
        disable iff (1'b0) $rose(sys_rst) && !reset_float |=> !reset_float) else $error("reset too fast");
endmodule
bind ext_bus_hold_and_reset_release hold_monitor mon (.*);

// File: bus_hold_partner.sv
// far-side master that asks for the memory bus
// assumes calls come from the bench's falling-edge process
`timescale 1ns/1ps
module bus_hold_partner
(
    input wire ref_clk,
    input wire bus_hold_grant_n,
    output reg hold_req_n
);
    initial hold_req_n = 1'b1;
    // gives up after 40 clocks so a missing grant cannot hang the run
    task grab(output integer w);
        begin
            @(negedge ref_clk);
            hold_req_n = 1'b0;
            w = 0;
            while (bus_hold_grant_n !== 1'b0 && w < 40)
            begin
                @(negedge ref_clk);
                w = w + 1;
            end
        end
    endtask
    task drop;
        begin
            @(negedge ref_clk);
            hold_req_n = 1'b1;
        end
    endtask
endmodule

// File: ext_bus_hold_and_reset_release_test.sv
// self-checking bench for the hold arbiter
// assumes the partner owns the hold request
`timescale 1ns/1ps
module ext_bus_hold_and_reset_release_test;
    reg ref_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg hold_ignore_setting = 1'b0;
    reg access_busy = 1'b0;
    wire clk_en = 1'b1;
    wire hold_req_n, access_inhibit, bus_hold_grant_n, ext_bus_float, reset_float, ext_bus_oe_n, host_serial_oe_n;
    integer err_total = 0;
    integer cmp_count = 0;
    integer w;
    always #4 ref_clk = ~ref_clk;
    ext_bus_hold_and_reset_release dut (.*);
    bus_hold_partner far (.*);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                err_total = err_total + 1;
                $display("unexpected t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task ungrab;
        begin
            far.drop;
            repeat (7) @(negedge ref_clk);
            chk({bus_hold_grant_n, ext_bus_oe_n, access_inhibit}, 32'h4);
        end
    endtask
    task finish_test;
        begin
            $display("compares %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task test_idle;
        begin
            far.grab(w);
            chk(w, 32'h6);
            chk({ext_bus_float, ext_bus_oe_n, access_inhibit}, 32'h7);
            ungrab;
            $display("idle hold done");
        end
    endtask
    task test_busy;
        begin
            access_busy = 1'b1;
            fork
                far.grab(w);
                begin
                    repeat (8) @(negedge ref_clk);
                    chk(bus_hold_grant_n, 32'h1);
                    access_busy = 1'b0;
                end
            join
            chk(w > 8, 32'h1);
            ungrab;
            $display("busy hold done");
        end
    endtask
    task test_ignore;
        begin
            hold_ignore_setting = 1'b1;
            far.grab(w);
            chk(w, 32'h28);
            hold_ignore_setting = 1'b0;
            repeat (10) @(negedge ref_clk);
            chk(bus_hold_grant_n, 32'h0);
            ungrab;
            $display("ignore hold done");
        end
    endtask
    task test_reset;
        begin
            sys_rst = 1'b1;
            @(negedge ref_clk);
            chk({reset_float, host_serial_oe_n, ext_bus_oe_n}, 32'h0);
            repeat (3) @(negedge ref_clk);
            chk({reset_float, host_serial_oe_n, ext_bus_oe_n}, 32'h7);
            repeat (6) @(negedge ref_clk);
            sys_rst = 1'b0;
            repeat (3) @(negedge ref_clk);
            chk({reset_float, host_serial_oe_n, ext_bus_oe_n}, 32'h0);
            $display("reset float done");
        end
    endtask
    initial
    begin
        repeat (5) @(negedge ref_clk); // single-rate clock, nothing to settle
        sys_rst = 1'b0;
        test_idle;
        test_busy;
        test_ignore;
        test_reset;
        finish_test;
    end
    initial
    begin
        #4000;
        err_total = err_total + 1;
        finish_test;
    end
endmodule
